/* File: lpmc_ctrl.sv */
// Contract
// R1 - stop: core clocks, PLL, fast oscillators off
// R2 - stop keeps all SRAM and registers
// R3 - stop grants peripheral fast RC requests
// R4 - stop0 keeps main regulator on
// R5 - stop2 puts core in low leakage
// R6 - stop exit clock: multispeed or fast RC
// R7 - standby: regulator and fast oscillators off
// R8 - brownout monitor stays on in standby
// R9 - standby I/O pulls follow software choice
// R10 - standby loses main SRAM and registers
// R11 - retention keeps retained SRAM in standby
// R12 - standby wake sources incl watchdog, CLOCK_SECURITY_CHECK
// R13 - standby wake clock multispeed 8 MHz
// R14 - shutdown: regulator and all RC oscillators off
// R15 - shutdown has no brownout or monitoring
// R16 - shutdown loses both SRAMs and registers
// R17 - shutdown wakes on pin, wake pin, RTC
// R18 - shutdown wake clock multispeed 4 MHz
// R19 - RTC kept or stopped per software
// R20 - slow crystal optional in every mode
// R21 - slow internal RC never in shutdown
// R22 - reset starts in run mode
// R23 - sleep stops only the CPU
// R24 - software sets target before entry request; code takes the target from the write that carries the entry bit
module lpmc_ctrl
   import lpmc_pkg::*;
#(
   parameter int N_WAKE = 2,
   parameter int N_IO   = 8
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // wake and event sources
   input  wire logic              periph_event,
   input  wire logic              stop_wake_event,
   input  wire logic              periph_hsi_req,
   input  wire logic              external_reset_pin_n,
   input  wire logic              watchdog_reset,
   input  wire logic [N_WAKE-1:0] wake_pin,
   input  wire logic              rtc_alarm,
   input  wire logic              rtc_periodic,
   input  wire logic              rtc_timestamp,
   input  wire logic              rtc_tamper,
   input  wire logic              lse_fail,
   // oscillator enables
   output logic                   pll_en,
   output logic                   multispeed_rc_osc_en,
   output logic [1:0]             multispeed_rc_osc_range,
   output logic                   fast_internal_rc_en,
   output logic                   slow_internal_rc_en,
   output logic                   slow_crystal_en,
   output logic                   sysclk_sel,
   // clocks, supplies and domains
   output logic                   cpu_clk_en,
   output logic                   core_clk_en,
   output logic                   main_reg_en,
   output logic                   lp_reg_en,
   output logic                   core_power_en,
   output logic                   core_low_leak,
   output logic                   main_sram_pwr,
   output logic                   retained_sram_pwr,
   output logic                   core_state_reset,
   // monitors and rtc
   output logic                   brownout_reset_monitor_en,
   output logic                   supply_monitor_en,
   output logic                   rtc_en,
   output logic                   lse_check_en,
   // standby i/o control
   output logic                   io_hold,
   output logic [N_IO-1:0]        io_pull_up,
   output logic [N_IO-1:0]        io_pull_down
);

   typedef struct packed {
      lpmc_mode_t        mode;
      logic [CTRL_W-1:0] ctrl;
      logic [N_WAKE-1:0] wake_en;
      logic [N_WAKE-1:0] wake_pol;
      logic [N_WAKE-1:0] wake_prev;
      logic [N_IO-1:0]   pu;
      logic [N_IO-1:0]   pd;
      logic [FLG_W-1:0]  flags;
      logic [31:0]       rdata;
      logic              slverr;
      logic              pll;
      logic              multispeed_rc_osc;
      logic [1:0]        msi_rng;
      logic              hsi;
      logic              slow_internal_rc;
      logic              lse;
      logic              sclk;
      logic              cpu_clk;
      logic              core_clk;
      logic              main_reg;
      logic              lp_reg;
      logic              core_pwr;
      logic              low_leak;
      logic              main_sram;
      logic              retained_sram;
      logic              core_rst;
      logic              bor;
      logic              pvd;
      logic              rtc;
      logic              clock_security_check;
      logic              hold;
   } lpmc_state_t;

   lpmc_state_t s;
   lpmc_state_t next_s;

   logic              access;
   logic              wr;
   logic [N_WAKE-1:0] edge_hit;
   logic              stop_mode;
   logic              off_mode;
   logic              rtc_any;
   logic              ev_pin;

   always_comb
   begin
      next_s    = s;
      access    = psel && penable;
      wr        = access && pwrite;
      rtc_any   = rtc_alarm || rtc_periodic || rtc_timestamp || rtc_tamper;
      ev_pin    = !external_reset_pin_n;
      // polarity bit set selects the falling edge, chosen per pin
      edge_hit  = s.wake_en & ((s.wake_pol & s.wake_prev & ~wake_pin) |
                               (~s.wake_pol & ~s.wake_prev & wake_pin));
      stop_mode = (s.mode == LPMC_STOP0) || (s.mode == LPMC_STOP1) ||
                  (s.mode == LPMC_STOP2);
      off_mode  = (s.mode == LPMC_STANDBY) || (s.mode == LPMC_SHUTDOWN);
      next_s.wake_prev = wake_pin;
      next_s.slverr    = 1'b0;
      next_s.rdata     = '0;

      // register writes; the entry bit is a one-shot, never stored
      if (wr)
      begin
         if (paddr == OFS_CTRL)
         begin
            next_s.ctrl = pwdata[CTRL_W-1:0];
            next_s.ctrl[CTRL_ENTER] = 1'b0;
         end
         else if (paddr == OFS_WAKECFG)
         begin
            next_s.wake_en  = pwdata[N_WAKE-1:0];
            next_s.wake_pol = pwdata[WCFG_POL_LO +: N_WAKE];
         end
         else if (paddr == OFS_IOPULL)
         begin
            next_s.pu = pwdata[N_IO-1:0];
            next_s.pd = pwdata[IOPULL_DN_LO +: N_IO];
         end
         else if (paddr == OFS_FLAGS)
         begin
            next_s.flags = s.flags & ~pwdata[FLG_W-1:0];
         end
         else if (paddr != OFS_STATUS)
         begin
            next_s.slverr = 1'b1;
         end
      end
      else if (access)
      begin
         if (paddr == OFS_CTRL)
         begin
            next_s.rdata[CTRL_W-1:0] = s.ctrl;
         end
         else if (paddr == OFS_WAKECFG)
         begin
            next_s.rdata[N_WAKE-1:0]             = s.wake_en;
            next_s.rdata[WCFG_POL_LO +: N_WAKE]  = s.wake_pol;
         end
         else if (paddr == OFS_IOPULL)
         begin
            next_s.rdata[N_IO-1:0]               = s.pu;
            next_s.rdata[IOPULL_DN_LO +: N_IO]   = s.pd;
         end
         else if (paddr == OFS_STATUS)
         begin
            next_s.rdata[2:0]            = s.mode;
            next_s.rdata[STAT_HSI_GRANT] = s.hsi;
         end
         else if (paddr == OFS_FLAGS)
         begin
            next_s.rdata[FLG_W-1:0] = s.flags;
         end
         else
         begin
            next_s.slverr = 1'b1;
         end
      end

      next_s.core_rst = 1'b0;
      // mode sequencing; wake flags are set after the clear so set wins
      case (s.mode)
         LPMC_RUN:
         begin
            if (wr && paddr == OFS_CTRL && pwdata[CTRL_ENTER])
            begin
               // target taken only from the value written with the entry bit, not the stored one [R24]
               case (pwdata[CTRL_TGT_HI:CTRL_TGT_LO])
                  TGT_SLEEP:    next_s.mode = LPMC_SLEEP;
                  TGT_STOP0:    next_s.mode = LPMC_STOP0;
                  TGT_STOP1:    next_s.mode = LPMC_STOP1;
                  TGT_STOP2:    next_s.mode = LPMC_STOP2;
                  TGT_STANDBY:  next_s.mode = LPMC_STANDBY;
                  TGT_SHUTDOWN: next_s.mode = LPMC_SHUTDOWN;
                  default:      next_s.mode = LPMC_RUN;
               endcase
            end
         end
         LPMC_SLEEP:
         begin
            if (periph_event)
            begin
               next_s.mode = LPMC_RUN; // [R23]
            end
         end
         LPMC_STOP0, LPMC_STOP1, LPMC_STOP2:
         begin
            if (stop_wake_event || ev_pin)
            begin
               // registers and sram untouched across stop [R2]
               next_s.mode = LPMC_RUN;
               next_s.flags[FLG_FROM_STOP] = 1'b1;
               next_s.sclk = s.ctrl[CTRL_STOP_HSI] ? SYSCLK_HSI : SYSCLK_MSI; // [R6]
               next_s.msi_rng = MSI_48MHZ; // [R6]
            end
         end
         LPMC_STANDBY:
         begin
            if (ev_pin || watchdog_reset || (|edge_hit) || rtc_any ||
                (lse_fail && s.ctrl[CTRL_LSE_KEEP])) // [R12]
            begin
               next_s.mode     = LPMC_RUN;
               next_s.core_rst = 1'b1;
               // only backup-domain and standby-circuit settings survive [R10]
               next_s.ctrl = s.ctrl & ((CTRL_W'(1) << CTRL_RETAIN) |
                                       (CTRL_W'(1) << CTRL_RTC_KEEP) |
                                       (CTRL_W'(1) << CTRL_LSE_KEEP) |
                                       (CTRL_W'(1) << CTRL_LSI_KEEP));
               next_s.sclk    = SYSCLK_MSI; // [R13]
               next_s.msi_rng = MSI_8MHZ; // [R13]
               next_s.flags[FLG_FROM_STBY] = 1'b1;
               next_s.flags[FLG_RESET_PIN] = s.flags[FLG_RESET_PIN] | ev_pin;
               next_s.flags[FLG_WATCHDOG]  = s.flags[FLG_WATCHDOG] | watchdog_reset;
               next_s.flags[FLG_WAKE_PIN]  = s.flags[FLG_WAKE_PIN] | (|edge_hit);
               next_s.flags[FLG_RTC]       = s.flags[FLG_RTC] | rtc_any;
               next_s.flags[FLG_LSE_FAIL]  = s.flags[FLG_LSE_FAIL] | lse_fail;
            end
         end
         LPMC_SHUTDOWN:
         begin
            // watchdog and slow crystal failure cannot wake from here [R17]
            if (ev_pin || (|edge_hit) || rtc_any)
            begin
               next_s.mode     = LPMC_RUN;
               next_s.core_rst = 1'b1;
               // i/o pulls and retention are lost too [R16]
               next_s.ctrl = s.ctrl & ((CTRL_W'(1) << CTRL_RTC_KEEP) |
                                       (CTRL_W'(1) << CTRL_LSE_KEEP));
               next_s.pu      = '0;
               next_s.pd      = '0;
               next_s.sclk    = SYSCLK_MSI; // [R18]
               next_s.msi_rng = MSI_4MHZ; // [R18]
               next_s.flags[FLG_FROM_SHDN] = 1'b1;
               next_s.flags[FLG_RESET_PIN] = s.flags[FLG_RESET_PIN] | ev_pin;
               next_s.flags[FLG_WAKE_PIN]  = s.flags[FLG_WAKE_PIN] | (|edge_hit);
               next_s.flags[FLG_RTC]       = s.flags[FLG_RTC] | rtc_any;
            end
         end
         default:
         begin
            next_s.mode = LPMC_RUN;
         end
      endcase

      // output decode from the mode being entered, so outputs are registered
      next_s.cpu_clk  = (next_s.mode == LPMC_RUN);
      next_s.core_clk = (next_s.mode == LPMC_RUN) || (next_s.mode == LPMC_SLEEP); // [R1] [R23]
      next_s.pll      = next_s.core_clk && next_s.ctrl[CTRL_PLL_ON]; // [R1] [R7] [R14]
      next_s.multispeed_rc_osc      = next_s.core_clk; // [R1] [R7] [R14]
      // hsi in stop only on peripheral demand; mode is not left [R3]
      next_s.hsi      = (next_s.core_clk && next_s.sclk == SYSCLK_HSI) ||
                        ((next_s.mode == LPMC_STOP0 || next_s.mode == LPMC_STOP1 ||
                          next_s.mode == LPMC_STOP2) && periph_hsi_req); // [R1] [R3]
      next_s.slow_internal_rc      = next_s.ctrl[CTRL_LSI_KEEP] && (next_s.mode != LPMC_SHUTDOWN); // [R21]
      next_s.lse      = next_s.ctrl[CTRL_LSE_KEEP]; // [R20]
      next_s.main_reg = next_s.core_clk || (next_s.mode == LPMC_STOP0); // [R4]
      next_s.lp_reg   = (next_s.mode == LPMC_STOP1) || (next_s.mode == LPMC_STOP2) ||
                        (next_s.mode == LPMC_STANDBY && next_s.ctrl[CTRL_RETAIN]); // [R11]
      next_s.core_pwr = (next_s.mode != LPMC_STANDBY) && (next_s.mode != LPMC_SHUTDOWN); // [R7] [R14]
      next_s.low_leak = (next_s.mode == LPMC_STOP2); // [R5]
      next_s.main_sram    = next_s.core_pwr; // [R2] [R10] [R16]
      next_s.retained_sram    = next_s.core_pwr ||
                        (next_s.mode == LPMC_STANDBY && next_s.ctrl[CTRL_RETAIN]); // [R11] [R16]
      next_s.bor      = (next_s.mode != LPMC_SHUTDOWN); // [R8] [R15]
      next_s.pvd      = next_s.core_pwr; // [R15]
      next_s.rtc      = next_s.core_pwr || next_s.ctrl[CTRL_RTC_KEEP]; // [R19]
      next_s.clock_security_check      = next_s.lse && (next_s.mode != LPMC_SHUTDOWN);
      next_s.hold     = !next_s.core_pwr; // [R9]

      if (rst)
      begin
         next_s          = '0;
         next_s.mode     = LPMC_RUN; // [R22]
         next_s.multispeed_rc_osc      = 1'b1;
         next_s.msi_rng  = MSI_4MHZ;
         next_s.sclk     = SYSCLK_MSI;
         next_s.cpu_clk  = 1'b1;
         next_s.core_clk = 1'b1;
         next_s.main_reg = 1'b1;
         next_s.core_pwr = 1'b1;
         next_s.main_sram    = 1'b1;
         next_s.retained_sram    = 1'b1;
         next_s.bor      = 1'b1;
         next_s.pvd      = 1'b1;
         next_s.rtc      = 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      s <= next_s;
   end

   // zero wait state slave; read data and error are valid at the access edge
   assign pready                    = 1'b1;
   assign prdata                    = access && !wr ? next_s.rdata : '0;
   assign pslverr                   = access && next_s.slverr;
   assign pll_en                    = s.pll;
   assign multispeed_rc_osc_en      = s.multispeed_rc_osc;
   assign multispeed_rc_osc_range   = s.msi_rng;
   assign fast_internal_rc_en       = s.hsi;
   assign slow_internal_rc_en       = s.slow_internal_rc;
   assign slow_crystal_en           = s.lse;
   assign sysclk_sel                = s.sclk;
   assign cpu_clk_en                = s.cpu_clk;
   assign core_clk_en               = s.core_clk;
   assign main_reg_en               = s.main_reg;
   assign lp_reg_en                 = s.lp_reg;
   assign core_power_en             = s.core_pwr;
   assign core_low_leak             = s.low_leak;
   assign main_sram_pwr             = s.main_sram;
   assign retained_sram_pwr         = s.retained_sram;
   assign core_state_reset          = s.core_rst;
   assign brownout_reset_monitor_en = s.bor;
   assign supply_monitor_en         = s.pvd;
   assign rtc_en                    = s.rtc;
   assign lse_check_en              = s.clock_security_check;
   assign io_hold                   = s.hold;
   assign io_pull_up                = s.hold ? s.pu : '0; // [R9]
   assign io_pull_down              = s.hold ? s.pd : '0; // [R9]

endmodule : lpmc_ctrl

/* File: lpmc_ctrl_chk.sv */
module lpmc_ctrl_chk
   import lpmc_pkg::*;
#(
   parameter int N_WAKE = 2,
   parameter int N_IO   = 8
)(
   // clock and reset
   input wire logic              clk,
   input wire logic              rst,
   // wake sources
   input wire logic              external_reset_pin_n,
   input wire logic [N_WAKE-1:0] wake_pin,
   input wire logic              rtc_alarm,
   input wire logic              rtc_periodic,
   input wire logic              rtc_timestamp,
   input wire logic              rtc_tamper,
   // power outputs
   input wire logic              pll_en,
   input wire logic              multispeed_rc_osc_en,
   input wire logic [1:0]        multispeed_rc_osc_range,
   input wire logic              fast_internal_rc_en,
   input wire logic              slow_internal_rc_en,
   input wire logic              sysclk_sel,
   input wire logic              cpu_clk_en,
   input wire logic              core_clk_en,
   input wire logic              main_reg_en,
   input wire logic              core_power_en,
   input wire logic              core_low_leak,
   input wire logic              main_sram_pwr,
   input wire logic              retained_sram_pwr,
   input wire logic              core_state_reset,
   input wire logic              brownout_reset_monitor_en,
   input wire logic              supply_monitor_en,
   input wire logic              io_hold,
   input wire logic [N_IO-1:0]   io_pull_up,
   input wire logic [N_IO-1:0]   io_pull_down
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   // powered core with stopped core clock only happens in a stop variant
   property p_stop_osc;
      core_power_en && !core_clk_en |-> !pll_en && !multispeed_rc_osc_en && !cpu_clk_en;
   endproperty
   a_stop_osc: assert property (p_stop_osc) else $error("oscillator running in stop");
   property p_stop_keep;
      core_power_en && !core_clk_en |-> main_sram_pwr && retained_sram_pwr;
   endproperty
   a_stop_keep: assert property (p_stop_keep) else $error("sram dropped in stop");
   property p_leak;
      core_low_leak |-> core_power_en && !core_clk_en && !main_reg_en;
   endproperty
   a_leak: assert property (p_leak) else $error("low leakage outside stop2");
   property p_off;
      !core_power_en |-> !main_reg_en && !pll_en && !multispeed_rc_osc_en && !fast_internal_rc_en;
   endproperty
   a_off: assert property (p_off) else $error("oscillator on with core off");
   property p_shdn;
      !brownout_reset_monitor_en |-> !supply_monitor_en && !slow_internal_rc_en
         && !retained_sram_pwr && !main_sram_pwr && !core_power_en;
   endproperty
   a_shdn: assert property (p_shdn) else $error("shutdown keeps power");
   property p_pull;
      !io_hold |-> io_pull_up == '0 && io_pull_down == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("pulls applied without hold");
   property p_wake_clk;
      core_state_reset |-> core_power_en && sysclk_sel == SYSCLK_MSI
         && multispeed_rc_osc_range != MSI_48MHZ ##1 !core_state_reset;
   endproperty
   a_wake_clk: assert property (p_wake_clk) else $error("bad clock after wake");
   // watchdog and slow crystal failure are left out of the quiet set on purpose
   property p_shdn_stay;
      !brownout_reset_monitor_en && external_reset_pin_n && $stable(wake_pin) && !rtc_alarm
         && !rtc_periodic && !rtc_timestamp && !rtc_tamper |=> !brownout_reset_monitor_en;
   endproperty
   a_shdn_stay: assert property (p_shdn_stay) else $error("shutdown left on bad source");
endmodule : lpmc_ctrl_chk

bind lpmc_ctrl lpmc_ctrl_chk #(.N_WAKE(N_WAKE), .N_IO(N_IO)) lpmc_ctrl_chk_i (.*);

/* File: lpmc_pkg.sv */
package lpmc_pkg;

   // power modes held by the controller
   typedef enum logic [2:0] {
      LPMC_RUN,
      LPMC_SLEEP,
      LPMC_STOP0,
      LPMC_STOP1,
      LPMC_STOP2,
      LPMC_STANDBY,
      LPMC_SHUTDOWN
   } lpmc_mode_t;

   // target mode codes written by software
   localparam logic [2:0] TGT_SLEEP    = 3'h0;
   localparam logic [2:0] TGT_STOP0    = 3'h1;
   localparam logic [2:0] TGT_STOP1    = 3'h2;
   localparam logic [2:0] TGT_STOP2    = 3'h3;
   localparam logic [2:0] TGT_STANDBY  = 3'h4;
   localparam logic [2:0] TGT_SHUTDOWN = 3'h5;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_WAKECFG  = 8'h04;
   localparam logic [7:0] OFS_IOPULL   = 8'h08;
   localparam logic [7:0] OFS_STATUS   = 8'h0c;
   localparam logic [7:0] OFS_FLAGS    = 8'h10;

   // control register fields
   localparam int CTRL_TGT_LO    = 0;
   localparam int CTRL_TGT_HI    = 2;
   localparam int CTRL_ENTER     = 3;
   localparam int CTRL_STOP_HSI  = 4;
   localparam int CTRL_RETAIN    = 5;
   localparam int CTRL_RTC_KEEP  = 6;
   localparam int CTRL_LSE_KEEP  = 7;
   localparam int CTRL_LSI_KEEP  = 8;
   localparam int CTRL_PLL_ON    = 9;
   localparam int CTRL_W         = 10;

   // wake config: enables low, polarity from this bit upward
   localparam int WCFG_POL_LO    = 8;
   localparam int IOPULL_DN_LO   = 16;

   // wake flag bits, write one to clear
   localparam int FLG_RESET_PIN  = 0;
   localparam int FLG_WATCHDOG   = 1;
   localparam int FLG_WAKE_PIN   = 2;
   localparam int FLG_RTC        = 3;
   localparam int FLG_LSE_FAIL   = 4;
   localparam int FLG_FROM_STBY  = 5;
   localparam int FLG_FROM_SHDN  = 6;
   localparam int FLG_FROM_STOP  = 7;
   localparam int FLG_W          = 8;

   // status register fields
   localparam int STAT_HSI_GRANT = 3;

   // system clock choice and oscillator range codes
   localparam logic       SYSCLK_MSI   = 1'b0;
   localparam logic       SYSCLK_HSI   = 1'b1;
   localparam logic [1:0] MSI_4MHZ     = 2'h0;
   localparam logic [1:0] MSI_8MHZ     = 2'h1;
   localparam logic [1:0] MSI_48MHZ    = 2'h2;

endpackage : lpmc_pkg

/* File: lpmc_wake_src_model.sv */
module lpmc_wake_src_model (
   // clock, reset and command
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       fire,
   input  wire logic [3:0] src,
   // wake and event lines
   output logic            external_reset_pin_n,
   output logic            watchdog_reset,
   output logic [1:0]      wake_pin,
   output logic            rtc_alarm,
   output logic            rtc_periodic,
   output logic            rtc_timestamp,
   output logic            rtc_tamper,
   output logic            lse_fail,
   output logic            stop_wake_event,
   output logic            periph_event
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] hold;
   logic [3:0] sel;
   logic [9:0] hit;
   always_ff @(posedge clk)
   begin
      if (rst)
         hold <= 2'h0;
      else if (fire)
      begin
         hold <= 2'h2;
         sel  <= src;
      end
      else if (hold != 2'h0)
         hold <= hold - 2'h1;
   end
   // two cycles wide so a one-cycle sampling skew cannot lose an event
   assign hit = (hold != 2'h0) ? (10'h1 << sel) : 10'h0;
   assign external_reset_pin_n = !hit[0];
   assign watchdog_reset = hit[1];
   assign wake_pin = {1'b0, hit[2]};
   assign rtc_alarm = hit[3];
   assign rtc_periodic = hit[4];
   assign rtc_timestamp = hit[5];
   assign rtc_tamper = hit[6];
   assign lse_fail = hit[7];
   assign stop_wake_event = hit[8];
   assign periph_event = hit[9];
endmodule : lpmc_wake_src_model

/* File: tb_low_power_mode_controller.sv */
module tb_low_power_mode_controller
   import lpmc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic        periph_hsi_req = 1'b0;
   logic        fire = 1'b0;
   logic [3:0]  src = 4'h0;
   logic [31:0] prdata, rd;
   logic        pready, pslverr, err, wake;
   logic        periph_event, stop_wake_event, external_reset_pin_n, watchdog_reset;
   logic        rtc_alarm, rtc_periodic, rtc_timestamp, rtc_tamper, lse_fail;
   logic [1:0]  wake_pin, multispeed_rc_osc_range;
   logic        pll_en, multispeed_rc_osc_en, fast_internal_rc_en, slow_internal_rc_en;
   logic        slow_crystal_en, sysclk_sel, cpu_clk_en, core_clk_en, main_reg_en, lp_reg_en;
   logic        core_power_en, core_low_leak, main_sram_pwr, retained_sram_pwr, core_state_reset;
   logic        brownout_reset_monitor_en, supply_monitor_en, rtc_en, lse_check_en, io_hold;
   logic [7:0]  io_pull_up, io_pull_down;
   int          failures = 0;
   int          check_count = 0;
   int          cycles = 0;

   lpmc_ctrl lpmc_ctrl_i (.*);
   lpmc_wake_src_model lpmc_wake_src_model_i (.*);

   initial
   begin
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         final_report();
      end
   end

   task automatic final_report();
      $display("checks %0d, mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         $display("unexpected %s: expected %h, seen %h", nm, exp, got);
         failures++;
      end
   endtask : chk
   // request held until pready is seen high at a rising edge; answer taken there
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_n(input int n);
      repeat (n) @(negedge clk);
   endtask : wait_n
   task automatic pulse(input logic [3:0] s);
      @(posedge clk);
      fire <= 1'b1;
      src  <= s;
      @(posedge clk);
      fire <= 1'b0;
   endtask : pulse

   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      wait_n(1);
      chk("reset outputs", 32'h3fc0, {cpu_clk_en, core_clk_en, multispeed_rc_osc_en,
         main_reg_en, core_power_en, main_sram_pwr, retained_sram_pwr,
         brownout_reset_monitor_en, pll_en, fast_internal_rc_en, io_hold, sysclk_sel,
         multispeed_rc_osc_range});
      apb(0, OFS_STATUS, 32'h0);
      chk("reset mode", 32'h0, rd[3:0]);
      $display("test reset done");
      apb(1, OFS_WAKECFG, 32'h1);
      apb(1, OFS_STATUS, 32'h7);
      apb(0, OFS_WAKECFG, 32'h0);
      chk("wakecfg", 32'h1, rd);
      apb(0, OFS_STATUS, 32'h0);
      chk("status", 32'h0, rd[3:0]);
      apb(1, 8'h14, 32'h1);
      chk("unmapped write error", 32'h1, err);
      apb(0, 8'h14, 32'h0);
      chk("unmapped read", 32'h1, {rd[30:0], err});
      $display("test registers done");
      apb(1, OFS_CTRL, 32'(TGT_SLEEP) + 32'h8);
      wait_n(2);
      chk("sleep clocks", 32'h1, {cpu_clk_en, core_clk_en});
      pulse(4'd9);
      wait_n(6);
      chk("sleep wake", 32'h3, {cpu_clk_en, core_clk_en});
      $display("test sleep done");
      for (int v = 0; v < 3; v++)
      begin
         apb(1, OFS_CTRL, 32'(TGT_STOP0) + 32'(v) + (v == 1 ? 32'h18 : 32'h8));
         wait_n(2);
         chk("stop clocks", 32'h0, {cpu_clk_en, core_clk_en, pll_en, multispeed_rc_osc_en,
            fast_internal_rc_en});
         chk("stop sram", 32'h3, {main_sram_pwr, retained_sram_pwr});
         chk("stop regs", (v == 0) ? 32'h2 : 32'h1, {main_reg_en, lp_reg_en});
         chk("stop low leak", 32'(v == 2), core_low_leak);
         @(posedge clk);
         periph_hsi_req <= 1'b1;
         wait_n(3);
         chk("stop fast rc grant", 32'h1, {core_clk_en, fast_internal_rc_en});
         @(posedge clk);
         periph_hsi_req <= 1'b0;
         pulse(4'd8);
         wait_n(6);
         chk("stop exit clock", {29'h0, v == 1 ? SYSCLK_HSI : SYSCLK_MSI, MSI_48MHZ},
            {sysclk_sel, multispeed_rc_osc_range});
      end
      $display("test stop done");
      for (int m = 0; m < 2; m++)
         for (int s = 0; s < 8; s++)
         begin
            wake = (m == 0) || (s != 1 && s != 7);
            apb(1, OFS_IOPULL, 32'h00a5_005a);
            apb(1, OFS_CTRL, (m == 1 ? 32'(TGT_SHUTDOWN) : 32'(TGT_STANDBY))
               + (s == 2 ? 32'h1a8 : 32'h1e8));
            wait_n(2);
            chk("core off", 32'h0, {core_power_en, main_reg_en, pll_en, multispeed_rc_osc_en,
               fast_internal_rc_en, main_sram_pwr});
            chk("brownout", 32'(m == 0), brownout_reset_monitor_en);
            chk("supply monitor", 32'h0, supply_monitor_en);
            chk("retained sram", 32'(m == 0), retained_sram_pwr);
            chk("slow rc", 32'(m == 0), slow_internal_rc_en);
            chk("slow crystal", 32'h1, slow_crystal_en);
            chk("rtc kept", 32'(s != 2), rtc_en);
            chk("io pulls", 32'ha55a, {io_pull_down, io_pull_up});
            pulse(4'(s));
            wait_n(6);
            chk("woken", 32'(wake), core_power_en);
            if (!wake)
            begin
               pulse(4'd3);
               wait_n(6);
            end
            chk("wake clock", {29'h0, SYSCLK_MSI, m == 1 ? MSI_4MHZ : MSI_8MHZ},
               {sysclk_sel, multispeed_rc_osc_range});
         end
      $display("test standby and shutdown done");
      final_report();
   end
endmodule : tb_low_power_mode_controller
